// ===== cepi_checker.sv
// Port-level assertions for the cache control block
`timescale 1ns/1ps
module cepi_checker (
  input wire clk_i,
  input wire reset_i,
  input wire s_axi_awvalid_i,
  input wire s_axi_awready_o,
  input wire s_axi_wvalid_i,
  input wire s_axi_wready_o,
  input wire s_axi_bvalid_o,
  input wire s_axi_arvalid_i,
  input wire s_axi_arready_o,
  input wire s_axi_rvalid_o,
  input wire sram_power_request_o,
  input wire sram_power_acknowledge_i,
  input wire lookup_done_i,
  input wire lookup_found_i,
  input wire lookup_cacheable_read_i,
  input wire lookup_debug_i,
  input wire cache_active_o,
  input wire invalidate_busy_o,
  input wire hit_pulse_out_o,
  input wire miss_pulse_out_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wire q = lookup_done_i && lookup_cacheable_read_i && !lookup_debug_i;
  reg [7:0] busy_cnt_r;
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) busy_cnt_r <= 8'h00;
    else busy_cnt_r <= invalidate_busy_o ? busy_cnt_r + 8'h01 : 8'h00;
  end
  a_hit_pulse: assert property (q && lookup_found_i |=> hit_pulse_out_o)
    else $error("hit pulse missing");
  a_miss_pulse: assert property (q && !lookup_found_i |=> miss_pulse_out_o)
    else $error("miss pulse missing");
  a_pulse_cause: assert property (hit_pulse_out_o || miss_pulse_out_o |-> $past(q))
    else $error("pulse without lookup");
  a_active_req: assert property (cache_active_o |-> sram_power_request_o)
    else $error("active without power request");
  a_ack_loss: assert property (cache_active_o && !sram_power_acknowledge_i |=> !cache_active_o)
    else $error("active after ack loss");
  a_inv_abort: assert property (invalidate_busy_o && !sram_power_acknowledge_i |=> !invalidate_busy_o)
    else $error("invalidation not aborted");
  a_active_busy: assert property (cache_active_o |-> !invalidate_busy_o)
    else $error("active during invalidation");
  a_inv_len: assert property (busy_cnt_r <= 8'd64)
    else $error("invalidation too long");
  a_wr_resp: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
    && s_axi_wready_o |=> s_axi_bvalid_o) else $error("write response late");
  a_rd_resp: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read response late");
endmodule
bind cepi_ctrl cepi_checker cepi_checker_i (.clk_i(clk_i), .reset_i(reset_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .sram_power_request_o(sram_power_request_o),
  .sram_power_acknowledge_i(sram_power_acknowledge_i),
  .lookup_done_i(lookup_done_i), .lookup_found_i(lookup_found_i),
  .lookup_cacheable_read_i(lookup_cacheable_read_i), .lookup_debug_i(lookup_debug_i),
  .cache_active_o(cache_active_o), .invalidate_busy_o(invalidate_busy_o),
  .hit_pulse_out_o(hit_pulse_out_o), .miss_pulse_out_o(miss_pulse_out_o));

// ===== cepi_consts.vh
// Register map, field positions, reset values and timing counts for the cache control block
`ifndef CEPI_CONSTS_VH
`define CEPI_CONSTS_VH
`define CEPI_ADDR_CONTROL 12'h000
`define CEPI_ADDR_STATE 12'h004
`define CEPI_ADDR_IRQ_MASK 12'h008
`define CEPI_ADDR_IRQ_STAT 12'h00c
`define CEPI_ADDR_HIT_STAT 12'h014
`define CEPI_ADDR_MISS_STAT 12'h018
`define CEPI_CTL_EN 0
`define CEPI_CTL_INVALIDATE_REQUEST_BIT 1
`define CEPI_CTL_MANUAL_POWER_REQUEST_BIT 2
`define CEPI_CTL_MAN_POW 3
`define CEPI_CTL_MAN_INV 4
`define CEPI_CTL_PREFETCH 5
`define CEPI_CTL_STAT_EN 6
`define CEPI_CTL_RESET 7'h40
`define CEPI_ST_SRAM_POWER_STATE_BIT 4
`define CEPI_IRQ_POWER_ERROR_FLAG 0
`define CEPI_IRQ_MANUAL_INVALIDATE_ERROR_FLAG 1
`define CEPI_STATE_DISABLED 2'h0
`define CEPI_STATE_ENABLING 2'h1
`define CEPI_STATE_ENABLED 2'h2
`define CEPI_INV_CYCLES 8'h40
`define CEPI_RESP_OKAY 2'h0
`define CEPI_RESP_SLVERR 2'h2
`endif

// ===== cepi_ctrl.v
// Cache enable, SRAM power handshake, invalidation and statistics control with AXI4-Lite regs
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`include "cepi_consts.vh"

// Behaviour
// - Manual power bit clear selects automatic SRAM power; set uses manual request bit.
// - Manual invalidate bit clear invalidates automatically on enable; set waits for software.
// - Power request output asks for SRAMs; acknowledge means they are usable.
// - State bits 1:0 report enable state, zero meaning fully disabled.
// - State bit 4 follows the SRAM power acknowledge.
// - Enabling in manual power mode while SRAMs are unacknowledged flags a power error.
// - Manual mode keeps power request while control bit 2 stays set.
// - Losing SRAMs during invalidation aborts it and sets the power error flag.
// - Power error raises the interrupt unless masked.
// - Power error returns the block to idle and bypasses all transactions.
// - Manual invalidate while enabled raises a maskable invalidate error.
// - Enabling during manual invalidation delays enabled state until it completes.
// - Manual invalidation requests act only in manual invalidate mode.
// - Writing one to invalidate bit starts invalidation; hardware clears it at end.
// - Hit and miss counts are separate 32-bit saturating counters.
// - Reading a statistics register returns its count; any write clears it.
// - Statistics counters exist only when the build parameter equals one.
// - One-cycle hit pulse for a non-debug cacheable read found in cache.
// - One-cycle miss pulse for a non-debug cacheable read not found.
// - Hit and miss pulses are always produced.
// - Errors also clear the invalidate bit; software writes cannot clear it.
module cepi_ctrl #(
  parameter build_statistics_param = 1
) (
  // Clock and reset
  input wire clk_i,
  input wire reset_i,
  // AXI4-Lite write
  input wire [11:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  // AXI4-Lite read
  input wire [11:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  // SRAM power handshake
  output wire sram_power_request_o,
  input wire sram_power_acknowledge_i,
  // Lookup result from the cache datapath
  input wire lookup_done_i,
  input wire lookup_found_i,
  input wire lookup_cacheable_read_i,
  input wire lookup_debug_i,
  // Status to datapath and system
  output wire cache_active_o,
  output wire bypass_all_o,
  output wire prefetch_enable_o,
  output wire invalidate_busy_o,
  output reg hit_pulse_out_o,
  output reg miss_pulse_out_o,
  output wire irq_o
);

  reg [6:0] control_config_reg_r;
  reg [1:0] state_r;
  reg [1:0] irq_status_r;
  reg [1:0] irq_mask_r;
  reg inv_busy_r;
  reg [7:0] inv_cnt_r;
  reg auto_inv_done_r;
  reg [31:0] hit_cnt_r;
  reg [31:0] miss_cnt_r;
  reg [11:0] aw_addr_r;
  reg aw_held_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  reg w_held_r;

  wire ctl_en = control_config_reg_r[`CEPI_CTL_EN];
  wire man_pow = control_config_reg_r[`CEPI_CTL_MAN_POW];
  wire man_inv = control_config_reg_r[`CEPI_CTL_MAN_INV];
  wire ack = sram_power_acknowledge_i;

  function is_reg;
    input [11:0] addr;
    begin
      is_reg = (addr == `CEPI_ADDR_CONTROL) || (addr == `CEPI_ADDR_STATE) ||
               (addr == `CEPI_ADDR_IRQ_MASK) || (addr == `CEPI_ADDR_IRQ_STAT) ||
               (addr == `CEPI_ADDR_HIT_STAT) || (addr == `CEPI_ADDR_MISS_STAT);
    end
  endfunction

  // Saturating add; a wrapped count would understate activity
  function [31:0] sat_inc;
    input [31:0] val;
    begin
      sat_inc = (val == 32'hffffffff) ? val : val + 32'h00000001;
    end
  endfunction

  // Write channel: address and data may arrive in either order
  wire aw_have = aw_held_r | s_axi_awvalid_i;
  wire w_have = w_held_r | s_axi_wvalid_i;
  wire [11:0] wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr_i;
  wire [31:0] wr_data = w_held_r ? w_data_r : s_axi_wdata_i;
  wire [3:0] wr_strb = w_held_r ? w_strb_r : s_axi_wstrb_i;
  wire wr_fire = aw_have & w_have & ~s_axi_bvalid_o;
  assign s_axi_awready_o = ~aw_held_r & ~s_axi_bvalid_o;
  assign s_axi_wready_o = ~w_held_r & ~s_axi_bvalid_o;
  wire wr_lane0 = wr_fire & wr_strb[0];
  wire wr_ctl = wr_lane0 & (wr_addr == `CEPI_ADDR_CONTROL);
  wire wr_mask = wr_lane0 & (wr_addr == `CEPI_ADDR_IRQ_MASK);
  wire wr_stat = wr_lane0 & (wr_addr == `CEPI_ADDR_IRQ_STAT);
  wire wr_hit = wr_fire & (wr_addr == `CEPI_ADDR_HIT_STAT);
  wire wr_miss = wr_fire & (wr_addr == `CEPI_ADDR_MISS_STAT);

  // Invalidation control
  wire inv_set_req = wr_ctl & wr_data[`CEPI_CTL_INVALIDATE_REQUEST_BIT];
  wire man_inv_start = inv_set_req & man_inv & ~inv_busy_r &
                       ~control_config_reg_r[`CEPI_CTL_INVALIDATE_REQUEST_BIT];
  // Request while not idle is refused and flagged
  wire manual_invalidate_error_flag_ev = inv_set_req & man_inv & (state_r != `CEPI_STATE_DISABLED);
  // Sticky power error blocks enabling until software clears it
  wire want_en = ctl_en & ~irq_status_r[`CEPI_IRQ_POWER_ERROR_FLAG];
  wire auto_inv_start = want_en & ~man_inv & ~auto_inv_done_r & ~inv_busy_r &
                        (state_r == `CEPI_STATE_ENABLING) & ack;
  // Count starts at full length; last busy cycle sees one
  wire inv_last = inv_busy_r & (inv_cnt_r == 8'h01);
  // Losing the acknowledge mid-run leaves contents half cleared
  wire inv_abort = inv_busy_r & ~ack;
  // Auto power waits for the acknowledge; only manual power faults here
  wire en_power_error_flag = (state_r == `CEPI_STATE_ENABLING) & want_en & ~ack & man_pow;
  wire run_power_error_flag = (state_r == `CEPI_STATE_ENABLED) & ~ack;
  wire power_error_flag_ev = inv_abort | en_power_error_flag | run_power_error_flag;

  // Power request; auto mode holds it until the state is back at idle
  wire auto_req = want_en | inv_busy_r | (state_r != `CEPI_STATE_DISABLED);
  assign sram_power_request_o = man_pow ? control_config_reg_r[`CEPI_CTL_MANUAL_POWER_REQUEST_BIT] :
                                auto_req;

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_held_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `CEPI_RESP_OKAY;
    end else begin
      // Pending response blocks both channels, so one write at a time
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= is_reg(wr_addr) ? `CEPI_RESP_OKAY : `CEPI_RESP_SLVERR;
      end else begin
        if (s_axi_awvalid_i & s_axi_awready_o) begin
          aw_held_r <= 1'b1;
          aw_addr_r <= s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i & s_axi_wready_o) begin
          w_held_r <= 1'b1;
          w_data_r <= s_axi_wdata_i;
          w_strb_r <= s_axi_wstrb_i;
        end
        if (s_axi_bvalid_o & s_axi_bready_i) begin
          s_axi_bvalid_o <= 1'b0;
        end
      end
    end
  end

  // Control, interrupt and sequencing state
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      control_config_reg_r <= `CEPI_CTL_RESET;
      irq_mask_r <= 2'h0;
      irq_status_r <= 2'h0;
      state_r <= `CEPI_STATE_DISABLED;
      inv_busy_r <= 1'b0;
      inv_cnt_r <= 8'h00;
      auto_inv_done_r <= 1'b0;
    end else begin
      // Invalidate bit is set only by the start logic below
      if (wr_ctl) begin
        control_config_reg_r[0] <= wr_data[0];
        control_config_reg_r[6:2] <= wr_data[6:2];
      end
      // Set side written last so a new request beats a clear in the same cycle
      if (inv_last | inv_abort | manual_invalidate_error_flag_ev) begin
        control_config_reg_r[`CEPI_CTL_INVALIDATE_REQUEST_BIT] <= 1'b0;
      end
      if (man_inv_start & ~manual_invalidate_error_flag_ev) begin
        control_config_reg_r[`CEPI_CTL_INVALIDATE_REQUEST_BIT] <= 1'b1;
      end
      if (wr_mask) begin
        irq_mask_r <= wr_data[1:0];
      end
      // Write one to clear; a new event wins over the clear
      irq_status_r <= (irq_status_r & ~(wr_stat ? wr_data[1:0] : 2'h0)) |
                      {manual_invalidate_error_flag_ev, power_error_flag_ev};
      if (man_inv_start & ~manual_invalidate_error_flag_ev | auto_inv_start) begin
        inv_busy_r <= 1'b1;
        inv_cnt_r <= `CEPI_INV_CYCLES;
      end else if (inv_abort | inv_last) begin
        inv_busy_r <= 1'b0;
        inv_cnt_r <= 8'h00;
      end else if (inv_busy_r) begin
        inv_cnt_r <= inv_cnt_r - 8'h01;
      end
      // Keeps automatic invalidation from rerunning while enabling
      if (inv_last & ~man_inv) begin
        auto_inv_done_r <= 1'b1;
      end else if (state_r == `CEPI_STATE_DISABLED) begin
        auto_inv_done_r <= 1'b0;
      end
      // Enable sequencing; power errors fall straight back to idle
      case (state_r)
        `CEPI_STATE_DISABLED: begin
          if (want_en) begin
            state_r <= `CEPI_STATE_ENABLING;
          end
        end
        `CEPI_STATE_ENABLING: begin
          if (~want_en | en_power_error_flag) begin
            state_r <= `CEPI_STATE_DISABLED;
          end else if (ack & ~inv_busy_r & (man_inv | auto_inv_done_r)) begin
            state_r <= `CEPI_STATE_ENABLED;
          end
        end
        `CEPI_STATE_ENABLED: begin
          if (~want_en | run_power_error_flag) begin
            state_r <= `CEPI_STATE_DISABLED;
          end
        end
        default: begin
          state_r <= `CEPI_STATE_DISABLED;
        end
      endcase
    end
  end

  // Hit and miss pulses, independent of the statistics build option
  // Registered so each pulse stands exactly one cycle
  wire qual = lookup_done_i & lookup_cacheable_read_i & ~lookup_debug_i;
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      hit_pulse_out_o <= 1'b0;
      miss_pulse_out_o <= 1'b0;
    end else begin
      hit_pulse_out_o <= qual & lookup_found_i;
      miss_pulse_out_o <= qual & ~lookup_found_i;
    end
  end

  // Statistics counters, pruned when not built
  wire stat_run = control_config_reg_r[`CEPI_CTL_STAT_EN];
  generate
    if (build_statistics_param == 1) begin : g_stat
      always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          hit_cnt_r <= 32'h00000000;
          miss_cnt_r <= 32'h00000000;
        end else begin
          if (wr_hit) begin
            hit_cnt_r <= 32'h00000000;
          end else if (stat_run & hit_pulse_out_o) begin
            hit_cnt_r <= sat_inc(hit_cnt_r);
          end
          if (wr_miss) begin
            miss_cnt_r <= 32'h00000000;
          end else if (stat_run & miss_pulse_out_o) begin
            miss_cnt_r <= sat_inc(miss_cnt_r);
          end
        end
      end
    end else begin : g_nostat
      // Held at zero; a combinational block with no inputs would never run
      always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          hit_cnt_r <= 32'h00000000;
          miss_cnt_r <= 32'h00000000;
        end else begin
          hit_cnt_r <= 32'h00000000;
          miss_cnt_r <= 32'h00000000;
        end
      end
    end
  endgenerate

  // Read channel, one read outstanding
  assign s_axi_arready_o = ~s_axi_rvalid_o;
  // Power bit shows the live acknowledge, not a stored copy
  wire [31:0] state_word = {27'h0000000, ack, 2'h0, state_r};
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= `CEPI_RESP_OKAY;
    end else if (s_axi_arvalid_i & s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= `CEPI_RESP_OKAY;
      if (s_axi_araddr_i == `CEPI_ADDR_CONTROL) begin
        s_axi_rdata_o <= {25'h0000000, control_config_reg_r};
      end else if (s_axi_araddr_i == `CEPI_ADDR_STATE) begin
        s_axi_rdata_o <= state_word;
      end else if (s_axi_araddr_i == `CEPI_ADDR_IRQ_MASK) begin
        s_axi_rdata_o <= {30'h00000000, irq_mask_r};
      end else if (s_axi_araddr_i == `CEPI_ADDR_IRQ_STAT) begin
        s_axi_rdata_o <= {30'h00000000, irq_status_r};
      end else if (s_axi_araddr_i == `CEPI_ADDR_HIT_STAT) begin
        s_axi_rdata_o <= hit_cnt_r;
      end else if (s_axi_araddr_i == `CEPI_ADDR_MISS_STAT) begin
        s_axi_rdata_o <= miss_cnt_r;
      end else begin
        s_axi_rdata_o <= 32'h00000000;
        s_axi_rresp_o <= `CEPI_RESP_SLVERR;
      end
    end else if (s_axi_rvalid_o & s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // Interrupt: any unmasked sticky flag; a mask bit set to one blocks its flag
  assign irq_o = |(irq_status_r & ~irq_mask_r);
  assign cache_active_o = (state_r == `CEPI_STATE_ENABLED);
  // Anything short of enabled passes transactions through untouched
  assign bypass_all_o = ~cache_active_o;
  assign prefetch_enable_o = control_config_reg_r[`CEPI_CTL_PREFETCH];
  assign invalidate_busy_o = inv_busy_r;

endmodule

// ===== cepi_pwr_model.sv
// SRAM power controller model answering the power request handshake
`timescale 1ns/1ps
module cepi_pwr_model #(
  parameter DELAY = 3
) (
  // Clock and reset
  input wire clk_i,
  input wire reset_i,
  // Handshake
  input wire req_i,
  input wire kill_i,
  output reg ack_o
);
  reg [7:0] cnt_r;
  // Slow power-up; kill models SRAMs lost mid-operation
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i || !req_i || kill_i) begin
      ack_o <= 1'b0;
      cnt_r <= 8'h00;
    end else if (cnt_r == DELAY) begin
      ack_o <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule

// ===== tb_top.sv
// Self-checking bench for the cache control block
`timescale 1ns/1ps
`include "cepi_consts.vh"
module tb_top;
  reg clk_i = 0, reset_i = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  reg [11:0] awa = 0, ara = 0;
  reg [31:0] wd = 0, d;
  reg done = 0, fnd = 0, cach = 0, dbg = 0, kill = 0;
  reg [1:0] rsp;
  wire awrdy, wrdy, bv, arrdy, rv, req, ack, act, byp, busy, hit, miss, irq, pf;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  integer fails = 0, n_checks = 0, cyc = 0;
  cepi_ctrl #(.build_statistics_param(1)) cepi_ctrl_i (.clk_i(clk_i), .reset_i(reset_i),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awrdy),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arrdy),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr),
    .sram_power_request_o(req), .sram_power_acknowledge_i(ack),
    .lookup_done_i(done), .lookup_found_i(fnd), .lookup_cacheable_read_i(cach),
    .lookup_debug_i(dbg), .cache_active_o(act), .bypass_all_o(byp), .prefetch_enable_o(pf),
    .invalidate_busy_o(busy), .hit_pulse_out_o(hit), .miss_pulse_out_o(miss), .irq_o(irq));
  cepi_pwr_model #(.DELAY(3)) cepi_pwr_model_i (.clk_i(clk_i), .reset_i(reset_i),
    .req_i(req), .kill_i(kill), .ack_o(ack));
  initial forever #5 clk_i = ~clk_i;
  task ck(input string n, input [31:0] e, input [31:0] g);
    n_checks = n_checks + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // Address and data offered together, each released once taken
  task w(input [11:0] a, input [31:0] v);
    @(posedge clk_i);
    awa <= a; wd <= v; awv <= 1; wv <= 1; br <= 1;
    do begin
      @(posedge clk_i);
      if (awrdy) awv <= 0;
      if (wrdy) wv <= 0;
    end while (bv !== 1'b1);
    rsp = bresp;
    br <= 0;
  endtask
  task r(input [11:0] a);
    @(posedge clk_i);
    ara <= a; arv <= 1; rr <= 1;
    do begin
      @(posedge clk_i);
      if (arrdy) arv <= 0;
    end while (rv !== 1'b1);
    d = rdata; rsp = rresp;
    rr <= 0;
  endtask
  task cr(input string n, input [11:0] a, input [31:0] e);
    r(a);
    ck(n, e, d);
  endtask
  task lk(input f, input c, input g, input eh, input em);
    @(posedge clk_i);
    done <= 1; fnd <= f; cach <= c; dbg <= g;
    @(posedge clk_i);
    done <= 0;
    #1 ck("hit", eh, hit);
    ck("miss", em, miss);
  endtask
  task t_reset;
    cr("ctl", `CEPI_ADDR_CONTROL, 32'h40);
    cr("state", `CEPI_ADDR_STATE, 32'h0);
    cr("gap", 12'h010, 32'h0);
    ck("rresp", `CEPI_RESP_SLVERR, rsp);
    w(12'h010, 32'h0);
    ck("bresp", `CEPI_RESP_SLVERR, rsp);
    w(`CEPI_ADDR_CONTROL, 32'h60);
    #1 ck("prefetch", 1, pf);
    w(`CEPI_ADDR_CONTROL, 32'h40);
    #1 ck("prefetch", 0, pf);
  endtask
  task t_auto;
    w(`CEPI_ADDR_CONTROL, 32'h41);
    #1 ck("req", 1, req);
    repeat (80) @(posedge clk_i);
    cr("state", `CEPI_ADDR_STATE, 32'h12);
    w(`CEPI_ADDR_CONTROL, 32'h40);
    repeat (3) @(posedge clk_i);
    ck("req", 0, req);
    cr("state", `CEPI_ADDR_STATE, 32'h0);
    w(`CEPI_ADDR_CONTROL, 32'h42);
    cr("ctl", `CEPI_ADDR_CONTROL, 32'h40);
  endtask
  task t_manual;
    w(`CEPI_ADDR_CONTROL, 32'h58);
    #1 ck("req", 0, req);
    w(`CEPI_ADDR_CONTROL, 32'h5c);
    #1 ck("req", 1, req);
    repeat (5) @(posedge clk_i);
    cr("state", `CEPI_ADDR_STATE, 32'h10);
    w(`CEPI_ADDR_CONTROL, 32'h5e);
    ck("busy", 1, busy);
    w(`CEPI_ADDR_CONTROL, 32'h5c);
    cr("ctl", `CEPI_ADDR_CONTROL, 32'h5e);
    repeat (70) @(posedge clk_i);
    cr("ctl", `CEPI_ADDR_CONTROL, 32'h5c);
    w(`CEPI_ADDR_CONTROL, 32'h5d);
    repeat (3) @(posedge clk_i);
    cr("state", `CEPI_ADDR_STATE, 32'h12);
    w(`CEPI_ADDR_CONTROL, 32'h5f);
    cr("irqst", `CEPI_ADDR_IRQ_STAT, 32'h2);
    ck("irq", 1, irq);
    w(`CEPI_ADDR_IRQ_MASK, 32'h2);
    #1 ck("irq", 0, irq);
    w(`CEPI_ADDR_IRQ_STAT, 32'h2);
    w(`CEPI_ADDR_IRQ_MASK, 32'h0);
    w(`CEPI_ADDR_CONTROL, 32'h5c);
    repeat (3) @(posedge clk_i);
    cr("state", `CEPI_ADDR_STATE, 32'h10);
    w(`CEPI_ADDR_CONTROL, 32'h58);
    repeat (3) @(posedge clk_i);
    cr("state", `CEPI_ADDR_STATE, 32'h0);
  endtask
  task t_pwr_err;
    w(`CEPI_ADDR_CONTROL, 32'h59);
    repeat (3) @(posedge clk_i);
    cr("irqst", `CEPI_ADDR_IRQ_STAT, 32'h1);
    ck("irq", 1, irq);
    ck("bypass", 1, byp);
    cr("state", `CEPI_ADDR_STATE, 32'h0);
    w(`CEPI_ADDR_CONTROL, 32'h58);
    w(`CEPI_ADDR_IRQ_STAT, 32'h1);
  endtask
  task t_abort;
    w(`CEPI_ADDR_CONTROL, 32'h5c);
    repeat (5) @(posedge clk_i);
    w(`CEPI_ADDR_CONTROL, 32'h5e);
    kill <= 1;
    repeat (3) @(posedge clk_i);
    ck("busy", 0, busy);
    cr("ctl", `CEPI_ADDR_CONTROL, 32'h5c);
    cr("irqst", `CEPI_ADDR_IRQ_STAT, 32'h1);
    kill <= 0;
    w(`CEPI_ADDR_IRQ_STAT, 32'h1);
    w(`CEPI_ADDR_CONTROL, 32'h58);
  endtask
  task t_late_en;
    w(`CEPI_ADDR_CONTROL, 32'h5c);
    repeat (5) @(posedge clk_i);
    w(`CEPI_ADDR_CONTROL, 32'h5e);
    w(`CEPI_ADDR_CONTROL, 32'h5d);
    cr("state", `CEPI_ADDR_STATE, 32'h11);
    ck("active", 0, act);
    repeat (70) @(posedge clk_i);
    cr("state", `CEPI_ADDR_STATE, 32'h12);
    ck("active", 1, act);
    ck("bypass", 0, byp);
    w(`CEPI_ADDR_CONTROL, 32'h5c);
    w(`CEPI_ADDR_CONTROL, 32'h58);
  endtask
  task t_stats;
    lk(1, 1, 0, 1, 0);
    lk(0, 1, 0, 0, 1);
    lk(1, 1, 1, 0, 0);
    lk(1, 0, 0, 0, 0);
    lk(1, 1, 0, 1, 0);
    cr("hits", `CEPI_ADDR_HIT_STAT, 32'h2);
    cr("misses", `CEPI_ADDR_MISS_STAT, 32'h1);
    w(`CEPI_ADDR_HIT_STAT, 32'h5);
    cr("hits", `CEPI_ADDR_HIT_STAT, 32'h0);
    cr("misses", `CEPI_ADDR_MISS_STAT, 32'h1);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard well above the few hundred cycles the tests need
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      summarize;
    end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    reset_i <= 0;
    t_reset;
    t_auto;
    t_manual;
    t_pwr_err;
    t_abort;
    t_late_en;
    t_stats;
    summarize;
  end
endmodule
